// ### rtl/psr_pkg.sv
// psr_pkg: constants and carrier types for the pad status and id register bank.
// assumes one internal clock; the command decoder that feeds the bank is outside.
// Functional notes
// RL1 - pad readback register is read only; low ten bits come from raw pre-deglitch samples
// RL2 - bit 15 reads 0 while power-good pin is pulled low, else 1
// RL3 - bit 14 reads 0 while alert pin is pulled low, else 1
// RL4 - bits 13:10 give fault pin a..d drive state, 0 when driven low
// RL5 - bits 9:8 code second address select: 11 high, 10 float, 00 low
// RL6 - bits 7:6 code first address select the same way; 01 never produced
// RL7 - bits 5,4 second/first control levels; bits 3:0 fault pins a..d levels
// RL8 - address base bit 7 is reserved, read only, reads zero
// RL9 - address base low seven bits hold the serial target address base
// RL10 - sixteen bit identification register returns a fixed maker code
// RL11 - paged eight bit lot register per channel holds factory lot number
// RL12 - writes to read-only registers change nothing and leave pad drive alone
package psr_pkg;
    // ----------------------------------------------------------------
    // command codes (the bank's own command numbering)
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_PAD_READBACK = 8'he0;
    localparam logic [7:0] CMD_ADDR_BASE = 8'he1;
    localparam logic [7:0] CMD_MAKER_ID = 8'he2;
    localparam logic [7:0] CMD_LOT_NUMBER = 8'he3;
    // ----------------------------------------------------------------
    // fields and values
    // ----------------------------------------------------------------
    localparam int NUM_CHANNELS = 8;
    localparam int PAGE_W = 3;
    localparam int BIT_PWRGD = 15;
    localparam int BIT_ALERT = 14;
    localparam logic [1:0] SEL_HIGH = 2'h3;
    localparam logic [1:0] SEL_FLOAT = 2'h2;
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [6:0] ADDR_BASE_RST = 7'h5c;
    // arbitrary neutral value, not any real maker code
    localparam logic [15:0] MAKER_ID_VALUE = 16'h5a5a;
    // arbitrary default lot, loaded into all channels alike at reset
    localparam logic [7:0] LOT_DEFAULT = 8'h01;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pwrgd_low;
        logic alert_low;
        logic [3:0] fault_low;
    } psr_drive_t;
    typedef struct packed {
        logic sel_second_high;
        logic sel_second_float;
        logic sel_first_high;
        logic sel_first_float;
        logic ctrl_input_second;
        logic ctrl_input_first;
        logic [3:0] fault_pin;
    } psr_pads_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] cmd;
        logic [PAGE_W-1:0] page;
        logic [15:0] wdata;
    } psr_req_t;
endpackage

// ### rtl/psr_sync2.sv
// psr_sync2: two-flop synchroniser for a vector of pad levels.
// assumes the pads are asynchronous to i_clock.
`timescale 1ns/1ps
module psr_sync2 #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;
endmodule

// ### rtl/psr_regs.sv
// psr_regs: pad status readback, address base, maker id and paged lot registers.
// assumes a command decoder presents one read or write request per cycle;
// drive states come from on-chip logic on i_clock, pad levels from pins.
`timescale 1ns/1ps
module psr_regs (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // command port
    input wire psr_pkg::psr_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_ack,
    // pad drive state from on-chip logic
    input wire psr_pkg::psr_drive_t i_drive,
    // raw pad levels from pins
    input wire psr_pkg::psr_pads_t i_pads,
    // address base to the serial target
    output logic [6:0] o_addr_base
);
    // ----------------------------------------------------------------
    // pad sampling
    // ----------------------------------------------------------------
    // no deglitch on purpose: readback shows the bare synchronised level
    logic [9:0] pads_s;
    psr_sync2 #(.W(10)) u_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pads),
        .o_sync(pads_s)
    ); // RL1

    function automatic logic [1:0] sel_code(input logic high, input logic flt);
        // floating wins over level; 01 cannot come out of this
        if (flt) begin
            sel_code = psr_pkg::SEL_FLOAT;
        end else if (high) begin
            sel_code = psr_pkg::SEL_HIGH;
        end else begin
            sel_code = psr_pkg::SEL_LOW;
        end
    endfunction

    // request decode, shared by the write path and the checks
    function automatic logic rd_hit(input psr_pkg::psr_req_t req, input logic [7:0] cmd);
        rd_hit = req.rd && (req.cmd == cmd);
    endfunction

    function automatic logic wr_hit(input psr_pkg::psr_req_t req, input logic [7:0] cmd);
        wr_hit = req.wr && (req.cmd == cmd);
    endfunction

    // commands outside the bank read back as zero
    function automatic logic known_cmd(input logic [7:0] cmd);
        known_cmd = (cmd == psr_pkg::CMD_PAD_READBACK) || (cmd == psr_pkg::CMD_ADDR_BASE)
            || (cmd == psr_pkg::CMD_MAKER_ID) || (cmd == psr_pkg::CMD_LOT_NUMBER);
    endfunction

    logic [15:0] pad_word;
    always_comb begin
        pad_word[psr_pkg::BIT_PWRGD] = ~i_drive.pwrgd_low; // RL2
        pad_word[psr_pkg::BIT_ALERT] = ~i_drive.alert_low; // RL3
        pad_word[13:10] = ~i_drive.fault_low; // RL4
        pad_word[9:8] = sel_code(pads_s[9], pads_s[8]); // RL5
        pad_word[7:6] = sel_code(pads_s[7], pads_s[6]); // RL6
        pad_word[5:0] = pads_s[5:0]; // RL7
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [6:0] base_r;
    logic [6:0] base_nxt;
    logic [7:0] lot_r [psr_pkg::NUM_CHANNELS];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [6:0] base_out_r;

    always_comb begin
        base_nxt = base_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        ack_nxt = i_req.wr;
        if (wr_hit(i_req, psr_pkg::CMD_ADDR_BASE)) begin
            base_nxt = i_req.wdata[6:0]; // RL9
        end
        // writes to other commands fall through with no effect
        if (i_req.rd) begin
            rvalid_nxt = 1'b1;
            case (i_req.cmd)
                psr_pkg::CMD_PAD_READBACK: rdata_nxt = pad_word; // RL1
                psr_pkg::CMD_ADDR_BASE: rdata_nxt = {9'h000, base_r}; // RL8
                psr_pkg::CMD_MAKER_ID: rdata_nxt = psr_pkg::MAKER_ID_VALUE; // RL10
                psr_pkg::CMD_LOT_NUMBER: rdata_nxt = {8'h00, lot_r[i_req.page]}; // RL11
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            base_r <= psr_pkg::ADDR_BASE_RST;
            base_out_r <= psr_pkg::ADDR_BASE_RST;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            base_r <= base_nxt;
            base_out_r <= base_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            ack_r <= ack_nxt;
        end
    end

    // lot bytes are factory constants: never written by the command port
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < psr_pkg::NUM_CHANNELS; i++) begin
                lot_r[i] <= psr_pkg::LOT_DEFAULT; // RL12
            end
        end else begin
            for (int i = 0; i < psr_pkg::NUM_CHANNELS; i++) begin
                lot_r[i] <= lot_r[i];
            end
        end
    end

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_ack = ack_r;
    assign o_addr_base = base_out_r;

    // ----------------------------------------------------------------
    // check helpers
    // ----------------------------------------------------------------
    // edges since reset, saturating at 3; the sampled pad history is only
    // trusted once both synchroniser flops have refilled from the pins
    logic [1:0] since_rst_r;
    logic [1:0] since_rst_nxt;

    always_comb begin
        since_rst_nxt = since_rst_r;
        if (since_rst_r != 2'h3) begin
            since_rst_nxt = since_rst_r + 2'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            since_rst_r <= 2'h0;
        end else begin
            since_rst_r <= since_rst_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    // ----------------------------------------------------------------
    // pad readback checks
    // ----------------------------------------------------------------
    pwrgd_bit_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL2
        |=> o_rvalid && o_rdata[15] == !$past(i_drive.pwrgd_low))
        else $error("power-good drive bit wrong");

    alert_bit_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL3
        |=> o_rdata[14] == !$past(i_drive.alert_low))
        else $error("alert drive bit wrong");

    fault_drive_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL4
        |=> o_rdata[13:10] == ~$past(i_drive.fault_low))
        else $error("fault drive bits wrong");

    sel_second_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL5
        |=> o_rdata[9:8] != 2'h1)
        else $error("reserved select code");

    sel_first_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL6
        |=> o_rdata[7:6] != 2'h1)
        else $error("reserved select code");

    pad_level_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL7
        |=> o_rdata[5:0] == $past(i_pads[5:0], 3))
        else $error("pad levels not two-flop samples");

    // select codes rebuilt from the pins three edges back: high 11, float 10, low 00
    raw_readonly_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL1
        |=> o_rvalid && o_rdata[9:8] == {$past(i_pads[9] | i_pads[8], 3),
        $past(i_pads[9] & ~i_pads[8], 3)} && o_rdata[7:6] == {$past(i_pads[7] | i_pads[6], 3),
        $past(i_pads[7] & ~i_pads[6], 3)})
        else $error("select codes not raw pad samples");

    ctrl_level_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL7
        |=> o_rdata[5:4] == {$past(i_pads.ctrl_input_second, 3),
        $past(i_pads.ctrl_input_first, 3)})
        else $error("control levels wrong");

    fault_level_a: assert property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK) // RL7
        |=> o_rdata[3:0] == $past(i_pads.fault_pin, 3))
        else $error("fault pin levels wrong");

    // exactly two flops between pin and readback, no filter stage
    sync_depth_a: assert property (since_rst_r == 2'h3 |-> pads_s == $past(i_pads, 2)) // RL1
        else $error("pad sampling depth wrong");

    // ----------------------------------------------------------------
    // register checks
    // ----------------------------------------------------------------
    base_rsvd_a: assert property (rd_hit(i_req, psr_pkg::CMD_ADDR_BASE) // RL8
        |=> o_rdata[15:7] == 9'h000)
        else $error("reserved base bits set");

    base_write_a: assert property (wr_hit(i_req, psr_pkg::CMD_ADDR_BASE) // RL9
        |=> o_addr_base == $past(i_req.wdata[6:0]))
        else $error("address base not stored");

    base_read_a: assert property (rd_hit(i_req, psr_pkg::CMD_ADDR_BASE) // RL9
        |=> o_rdata[6:0] == $past(o_addr_base))
        else $error("address base readback differs from live base");

    maker_id_a: assert property (rd_hit(i_req, psr_pkg::CMD_MAKER_ID) // RL10
        |=> o_rdata == psr_pkg::MAKER_ID_VALUE)
        else $error("maker id wrong");

    lot_value_a: assert property (rd_hit(i_req, psr_pkg::CMD_LOT_NUMBER) // RL11
        |=> o_rdata == {8'h00, psr_pkg::LOT_DEFAULT})
        else $error("lot value wrong");

    lot_upper_a: assert property (rd_hit(i_req, psr_pkg::CMD_LOT_NUMBER) // RL11
        |=> o_rdata[15:8] == 8'h00)
        else $error("lot readback upper byte set");

    ro_write_a: assert property (i_req.wr && i_req.cmd != psr_pkg::CMD_ADDR_BASE // RL12
        |=> $stable(o_addr_base))
        else $error("write to read-only register had effect");

    // only a base write may move the address handed to the serial target
    base_hold_a: assert property (!wr_hit(i_req, psr_pkg::CMD_ADDR_BASE) // RL12
        |=> $stable(o_addr_base))
        else $error("address base moved without a write");

    unknown_read_a: assert property (i_req.rd && !known_cmd(i_req.cmd) // RL12
        |=> o_rdata == 16'h0000)
        else $error("unknown command read not zero");

    // ----------------------------------------------------------------
    // handshake checks
    // ----------------------------------------------------------------
    // every request is answered on the next edge and the strobes drop after one cycle
    read_answer_a: assert property (i_req.rd |=> o_rvalid) // RL1
        else $error("read not answered");

    rvalid_pulse_a: assert property (!i_req.rd |=> !o_rvalid) // RL1
        else $error("read valid held too long");

    write_ack_a: assert property (i_req.wr |=> o_ack) // RL12
        else $error("write not acknowledged");

    ack_pulse_a: assert property (!i_req.wr |=> !o_ack) // RL12
        else $error("write ack held too long");

    // read data stands until the next read
    rdata_hold_a: assert property (!i_req.rd |=> $stable(o_rdata)) // RL1
        else $error("read data changed without a read");

    // ----------------------------------------------------------------
    // reset check
    // ----------------------------------------------------------------
    // the default disable is switched off here so the reset values themselves are seen
    reset_state_a: assert property (disable iff (1'b0) i_sys_rst // RL9
        |=> !o_rvalid && !o_ack && o_addr_base == psr_pkg::ADDR_BASE_RST && o_rdata == 16'h0000)
        else $error("reset values wrong");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    pad_read_c: cover property (rd_hit(i_req, psr_pkg::CMD_PAD_READBACK));
    base_write_c: cover property (wr_hit(i_req, psr_pkg::CMD_ADDR_BASE)
        ##[1:4] rd_hit(i_req, psr_pkg::CMD_ADDR_BASE));
    lot_read_c: cover property (rd_hit(i_req, psr_pkg::CMD_LOT_NUMBER) && i_req.page == 3'h7);
    ro_write_c: cover property (wr_hit(i_req, psr_pkg::CMD_MAKER_ID));
    unknown_read_c: cover property (i_req.rd && !known_cmd(i_req.cmd));
endmodule

// ### tb/psr_host.sv
// psr_host: behavioural command host that feeds requests into the register bank.
// assumes the bank takes a request on the rising edge and answers one cycle later.
`timescale 1ns/1ps
module psr_host (
    // clock
    input wire logic i_clock,
    // request to the bank
    output psr_pkg::psr_req_t o_req
);
    initial begin
        o_req = '0;
    end

    // one request pulse; returns just after the edge where the answer lands
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [2:0] page,
                        input logic [15:0] wd);
        @(posedge i_clock);
        o_req.rd <= !wr;
        o_req.wr <= wr;
        o_req.cmd <= cmd;
        o_req.page <= page;
        o_req.wdata <= wd;
        @(posedge i_clock);
        o_req.rd <= 1'b0;
        o_req.wr <= 1'b0;
        // spoil the idle data so a stale word cannot pass for a fresh one
        o_req.wdata <= ~wd;
        #1;
    endtask
endmodule

// ### tb/pad_status_and_id_regs_test.sv
// pad_status_and_id_regs_test: self-checking bench for the pad status and id registers.
// assumes psr_regs answers reads and writes one cycle after the taking edge.
`timescale 1ns/1ps
module pad_status_and_id_regs_test;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    psr_pkg::psr_req_t req;
    psr_pkg::psr_drive_t drive = '0;
    psr_pkg::psr_pads_t pads = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic ack;
    logic [6:0] addr_base;
    int err_count = 0;
    int total_checks = 0;

    initial begin
        forever #20 i_clock = ~i_clock;
    end

    psr_host u_host (.i_clock(i_clock), .o_req(req));
    psr_regs u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_ack(ack), .i_drive(drive), .i_pads(pads), .o_addr_base(addr_base));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_chk(input string what, input logic [7:0] cmd, input logic [2:0] page,
                            input logic [15:0] exp);
        u_host.xfer(1'b0, cmd, page, 16'h0000);
        check("rvalid", 16'h0001, {15'h0000, rvalid});
        check(what, exp, rdata);
        // valid stands one cycle, the data until the next read
        @(posedge i_clock);
        #1;
        check("rvalid drop", 16'h0000, {15'h0000, rvalid});
        check(what, exp, rdata);
    endtask

    task automatic write_chk(input logic [7:0] cmd, input logic [15:0] wd);
        u_host.xfer(1'b1, cmd, 3'h0, wd);
        check("ack", 16'h0001, {15'h0000, ack});
        @(posedge i_clock);
        #1;
        check("ack drop", 16'h0000, {15'h0000, ack});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_ids();
        read_chk("maker id", psr_pkg::CMD_MAKER_ID, 3'h0, 16'h5a5a);
        for (int p = 0; p < 8; p++) begin
            read_chk("lot", psr_pkg::CMD_LOT_NUMBER, p[2:0], 16'h0001);
        end
        read_chk("unknown cmd", 8'h00, 3'h0, 16'h0000);
        $display("test ids done");
    endtask

    task automatic test_pads();
        logic [15:0] tbl [4];
        logic [1:0] c2;
        logic [1:0] c1;
        // drive state in bits 15:10, pin levels in 9:0; covers low, float and high on the second select, low and float on the first
        tbl = '{16'hfc00, 16'h03ff, 16'h5625, 16'ha95a};
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clock);
            drive <= tbl[i][15:10];
            pads <= tbl[i][9:0];
            repeat (4) @(posedge i_clock);
            // float wins over high in the select code
            c2 = tbl[i][8] ? 2'h2 : (tbl[i][9] ? 2'h3 : 2'h0);
            c1 = tbl[i][6] ? 2'h2 : (tbl[i][7] ? 2'h3 : 2'h0);
            read_chk("pads", psr_pkg::CMD_PAD_READBACK, 3'h0,
                {~tbl[i][15:10], c2, c1, tbl[i][5:0]});
        end
        $display("test pads done");
    endtask

    task automatic test_base();
        check("base reset", 16'h005c, {9'h000, addr_base});
        read_chk("base", psr_pkg::CMD_ADDR_BASE, 3'h0, 16'h005c);
        write_chk(psr_pkg::CMD_ADDR_BASE, 16'hffff);
        check("base out", 16'h007f, {9'h000, addr_base});
        read_chk("base bit7", psr_pkg::CMD_ADDR_BASE, 3'h0, 16'h007f);
        write_chk(psr_pkg::CMD_ADDR_BASE, 16'h0012);
        check("base out", 16'h0012, {9'h000, addr_base});
        $display("test base done");
    endtask

    task automatic test_ro_writes();
        write_chk(psr_pkg::CMD_PAD_READBACK, 16'h0000);
        write_chk(psr_pkg::CMD_MAKER_ID, 16'h1234);
        write_chk(psr_pkg::CMD_LOT_NUMBER, 16'h00ee);
        read_chk("maker id", psr_pkg::CMD_MAKER_ID, 3'h0, 16'h5a5a);
        read_chk("lot", psr_pkg::CMD_LOT_NUMBER, 3'h0, 16'h0001);
        read_chk("pads", psr_pkg::CMD_PAD_READBACK, 3'h0, 16'h569a);
        check("base kept", 16'h0012, {9'h000, addr_base});
        $display("test ro writes done");
    endtask

    task automatic test_reset();
        @(posedge i_clock);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        #1;
        check("base after reset", {9'h000, psr_pkg::ADDR_BASE_RST}, {9'h000, addr_base});
        check("rdata after reset", 16'h0000, rdata);
        read_chk("base reread", psr_pkg::CMD_ADDR_BASE, 3'h0,
            {9'h000, psr_pkg::ADDR_BASE_RST});
        $display("test reset done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        test_base();
        test_ids();
        test_pads();
        test_ro_writes();
        test_reset();
        report_and_stop();
    end

    // the whole run needs well under 300 cycles
    initial begin
        #(40 * 2000);
        err_count++;
        report_and_stop();
    end
endmodule
